// ### common/sdirc_pkg.sv
/*
 * Shared constants, encodings and the top-level state record of the reclocker control block.
 * Assumes a 100 MHz system clock; all times below are turned into cycle counts at that rate.
 */
`default_nettype none
package sdirc_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int ACQ_TIME_MS = 15;
    localparam int ACQ_CYCLES = ACQ_TIME_MS * 1000000 / CLK_PERIOD_NS;
    localparam int LOS_TIME_MS = 1;
    localparam int LOS_CYCLES = LOS_TIME_MS * 1000000 / CLK_PERIOD_NS;
    localparam int CLASS_DELAY_NS = 37;
    localparam int CLASS_DELAY_CYCLES = (CLASS_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CLK_ALIGN_PCT = 10;
    localparam logic [3:0] RATE_QUAL_LAST = 4'hf;
    localparam logic [2:0] CLASS_DELAY_LAST = 3'(CLASS_DELAY_CYCLES - 1);
    localparam logic QUIET_TRUE = 1'h0;
    localparam logic QUIET_COMP = 1'h1;

    typedef logic [20:0] sdirc_tmr_t;

    typedef enum logic [1:0] {
        RATE_AUTO = 2'b00,
        RATE_SD = 2'b01,
        RATE_HD = 2'b10,
        RATE_TEST = 2'b11
    } sdirc_rate_sel_t;

    typedef enum logic [2:0] {
        DET_NONE = 3'b000,
        DET_270 = 3'b001,
        DET_1483 = 3'b010,
        DET_1485 = 3'b011,
        DET_2967 = 3'b100,
        DET_2970 = 3'b101,
        DET_HARMONIC = 3'b110,
        DET_OTHER = 3'b111
    } sdirc_det_rate_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ACQUIRE = 2'b01,
        ST_LOCKED = 2'b10,
        ST_FORCED = 2'b11
    } sdirc_lock_state_t;

    typedef struct packed {
        sdirc_lock_state_t state;
        sdirc_tmr_t acq_cnt;
        sdirc_tmr_t los_cnt;
        logic [2:0] det_prev;
        logic [3:0] qual_cnt;
        logic [2:0] class_cnt;
        logic serial_prev;
        logic active;
        logic locked;
        logic rate_class;
        logic acq_restart;
        logic test_mode;
        logic prim_true;
        logic prim_comp;
        logic sec_true;
        logic sec_comp;
        logic sample_valid;
    } sdirc_state_t;

    localparam sdirc_state_t STATE_RESET = '{
        state: ST_IDLE, acq_cnt: 21'h0, los_cnt: 21'h0, det_prev: 3'h0, qual_cnt: 4'h0,
        class_cnt: 3'h0, serial_prev: 1'h0, active: 1'h0, locked: 1'h0, rate_class: 1'h0,
        acq_restart: 1'h0, test_mode: 1'h0, prim_true: QUIET_TRUE, prim_comp: QUIET_COMP,
        sec_true: QUIET_TRUE, sec_comp: QUIET_COMP, sample_valid: 1'h0
    };
endpackage
`default_nettype wire

// ### common/sdirc_stream_if.sv
/*
 * Half-bit sample stream between the clock-recovery side and the output stage.
 * Assumes both ends run on the system clock.
 */
`timescale 1ns/1ns
`default_nettype none
interface sdirc_stream_if;
    logic valid;
    logic ready;
    logic data_bit;
    logic half_bit;
    modport src (output valid, output data_bit, output half_bit, input ready);
    modport snk (input valid, input data_bit, input half_bit, output ready);
endinterface
`default_nettype wire

// ### src/sdirc_pin_sync.sv
/*
 * Two-flop synchroniser for a group of asynchronous pins.
 * Assumes each bit is an independent level; the detected-rate code is qualified downstream, the rate select code is not.
 */
`timescale 1ns/1ns
`default_nettype none
module sdirc_pin_sync #(
    parameter int WIDTH = 10
) (
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    input wire logic [WIDTH-1:0] pins_in,
    output logic [WIDTH-1:0] pins_out
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } sdirc_sync_t;

    sdirc_sync_t s;
    sdirc_sync_t next_s;

    always_comb begin
        next_s.stage1 = pins_in;
        next_s.stage2 = s.stage1;
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign pins_out = s.stage2;
endmodule // sdirc_pin_sync
`default_nettype wire

// ### src/sdirc_reclocker_ctrl.sv
/*
 * Control logic of a serial video reclocker: rate qualification, lock indication, bypass,
 * second-output selection and output silencing, with a two-entry buffer on the retimed path.
 * Assumes an analog clock-recovery front end reporting lock and a detected-rate code, and
 * delivering retimed half-bit samples on the system clock; pins arrive asynchronously.
 */
`timescale 1ns/1ns
`default_nettype none
// Operation
// - recognise and retime only 270, 1483, 1485, 2967 and 2970 Mbps streams
// - never declare lock on harmonics of a supported rate
// - at 143, 177, 360, 540 Mbps stay unlocked and bypass automatically
// - second output carries recovered clock when clock select high, data copy when low
// - undriven clock select reads low, so second output carries data by default
// - clock rising edge lies within a tenth of a period of the bit centre
// - low quiet input silences both outputs regardless of clock select
// - bypass with second output in clock mode silences the second output too
// - silenced output holds true and complement legs at fixed opposite levels
// - unsupported rate in auto bypass with clock mode gives undefined second output
// - rate select 00 auto, 01 fixed 270 Mbps, 10 fixed HD and 3G rates
// - undriven rate select pins read low, giving automatic detection
// - reclock 8B10B transport data at 270 Mbps in fixed or automatic mode
// - rate select also enters the manufacturer test mode
// - lock indicator high only with valid input present and loop locked
// - forced skip of retiming keeps lock indicator low
// - silencing takes priority over bypass
// - undriven quiet input reads high, outputs enabled by default
// - forced skip passes data unretimed; otherwise bypass when unlocked or unsupported
// - rate class high for 270 Mbps, low for HD/3G, low whenever unlocked
// - lock indicator asserted within the maximum acquisition time from first transition
module sdirc_reclocker_ctrl #(
    parameter int ACQ_LIMIT = sdirc_pkg::ACQ_CYCLES,
    parameter int LOS_LIMIT = sdirc_pkg::LOS_CYCLES
) (
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    input wire logic serial_in,
    input wire logic cdr_lock_in,
    input wire logic [2:0] cdr_rate_in,
    input wire logic outputs_quiet_n_in,
    input wire logic retime_skip_force_in,
    input wire logic second_output_clock_select_in,
    input wire logic [1:0] rate_select_in,
    input wire logic recovered_bit_in,
    input wire logic recovered_half_in,
    input wire logic recovered_valid_in,
    output logic recovered_ready_out,
    input wire logic driver_ready_in,
    output logic primary_serial_out_true_out,
    output logic primary_serial_out_comp_out,
    output logic second_serial_out_true_out,
    output logic second_serial_out_comp_out,
    output logic sample_valid_out,
    output logic lock_indicator_out,
    output logic rate_class_indicator_out,
    output logic acq_restart_out,
    output logic test_mode_out
);
    localparam int PIN_W = 10;

    sdirc_pkg::sdirc_state_t s;
    sdirc_pkg::sdirc_state_t next_s;

    logic [PIN_W-1:0] pins_raw;
    logic [PIN_W-1:0] pins;
    logic pin_serial;
    logic pin_cdr_lock;
    sdirc_pkg::sdirc_det_rate_t pin_rate;
    logic pin_quiet_n;
    logic pin_force;
    logic pin_clk_sel;
    sdirc_pkg::sdirc_rate_sel_t pin_mode;

    logic rx_edge;
    logic rate_ok;
    logic rate_qualified;
    logic bypass;
    logic buf_pop;
    logic drive_prim;
    logic drive_sec;
    logic prim_bit;
    logic sec_bit;
    logic prim_quiet;
    logic sec_quiet;

    sdirc_stream_if into_buf ();
    sdirc_stream_if from_buf ();

    assign pins_raw = {serial_in, cdr_lock_in, cdr_rate_in, outputs_quiet_n_in,
                       retime_skip_force_in, second_output_clock_select_in, rate_select_in};

    sdirc_pin_sync #(
        .WIDTH(PIN_W)
    ) u_pin_sync (
        .clk_sys_in(clk_sys_in),
        .rst_b_in(rst_b_in),
        .pins_in(pins_raw),
        .pins_out(pins)
    );

    assign pin_serial = pins[9];
    assign pin_cdr_lock = pins[8];
    assign pin_rate = sdirc_pkg::sdirc_det_rate_t'(pins[7:5]);
    // pad pull-up on the quiet pin: an open pin arrives high and leaves outputs live
    assign pin_quiet_n = pins[4];
    assign pin_force = pins[3];
    // pad pull-downs: an open pin arrives low, selecting data on the second output
    assign pin_clk_sel = pins[2];
    // and automatic rate detection on the selector
    assign pin_mode = sdirc_pkg::sdirc_rate_sel_t'(pins[1:0]);

    // rate acceptance per selector setting; 11 is treated exactly like automatic detection
    function automatic logic rate_allowed(input sdirc_pkg::sdirc_rate_sel_t mode,
                                          input sdirc_pkg::sdirc_det_rate_t det);
        logic sd_rate;
        logic hd_rate;
        sd_rate = (det == sdirc_pkg::DET_270);
        hd_rate = (det == sdirc_pkg::DET_1483) || (det == sdirc_pkg::DET_1485) ||
                  (det == sdirc_pkg::DET_2967) || (det == sdirc_pkg::DET_2970);
        case (mode)
            sdirc_pkg::RATE_SD: rate_allowed = sd_rate;
            sdirc_pkg::RATE_HD: rate_allowed = hd_rate;
            default: rate_allowed = sd_rate || hd_rate;
        endcase
    endfunction

    // harmonic and foreign rates (143/177/360/540) never qualify
    assign rate_ok = pin_cdr_lock && rate_allowed(pin_mode, pin_rate);
    // the rate code crosses as separate bits, so it must hold still before it counts
    assign rate_qualified = rate_ok && (s.qual_cnt == sdirc_pkg::RATE_QUAL_LAST);
    assign rx_edge = pin_serial ^ s.serial_prev;

    // retimed samples from the front end are on this clock, so they enter the buffer directly
    assign into_buf.valid = recovered_valid_in;
    assign into_buf.data_bit = recovered_bit_in;
    assign into_buf.half_bit = recovered_half_in;
    assign recovered_ready_out = into_buf.ready;

    sdirc_skid_buf u_skid_buf (
        .clk_sys_in(clk_sys_in),
        .rst_b_in(rst_b_in),
        .fill(into_buf.snk),
        .drain(from_buf.src)
    );

    // unlocked or forced means bypass; while bypassed the buffer is drained and discarded
    assign bypass = !s.locked;
    assign from_buf.ready = bypass || driver_ready_in;
    assign buf_pop = from_buf.valid && from_buf.ready;
    assign drive_prim = bypass || buf_pop;

    // second output: half flag is low for the first half of a bit, so the rising edge sits at the centre
    always_comb begin
        if (bypass) begin
            prim_bit = pin_serial;
            sec_bit = pin_serial;
        end else begin
            prim_bit = from_buf.data_bit;
            sec_bit = pin_clk_sel ? from_buf.half_bit : from_buf.data_bit;
        end
    end

    // silencing wins over bypass; clock mode under bypass is silenced, which also covers
    // the undefined clock an unsupported rate would otherwise produce
    assign prim_quiet = !pin_quiet_n;
    assign sec_quiet = !pin_quiet_n || (bypass && pin_clk_sel);
    assign drive_sec = drive_prim;

    always_comb begin
        next_s = s;
        next_s.acq_restart = 1'h0;
        next_s.sample_valid = 1'h0;
        next_s.serial_prev = pin_serial;
        next_s.test_mode = (pin_mode == sdirc_pkg::RATE_TEST);
        next_s.det_prev = pin_rate;

        // input activity: any transition within the loss window counts as valid data present
        if (rx_edge) begin
            next_s.active = 1'h1;
            next_s.los_cnt = 21'h0;
        end else if (s.los_cnt == sdirc_pkg::sdirc_tmr_t'(LOS_LIMIT - 1)) begin
            next_s.active = 1'h0;
        end else begin
            next_s.los_cnt = s.los_cnt + 21'h1;
        end

        if (rate_ok && (pin_rate == s.det_prev)) begin
            if (s.qual_cnt != sdirc_pkg::RATE_QUAL_LAST) begin
                next_s.qual_cnt = s.qual_cnt + 4'h1;
            end
        end else begin
            next_s.qual_cnt = 4'h0;
        end

        case (s.state)
            sdirc_pkg::ST_IDLE: begin
                if (pin_force) begin
                    next_s.state = sdirc_pkg::ST_FORCED;
                end else if (rx_edge) begin
                    next_s.state = sdirc_pkg::ST_ACQUIRE;
                    next_s.acq_cnt = 21'h0;
                end
            end
            sdirc_pkg::ST_ACQUIRE: begin
                if (pin_force) begin
                    next_s.state = sdirc_pkg::ST_FORCED;
                end else if (!s.active) begin
                    next_s.state = sdirc_pkg::ST_IDLE;
                end else if (rate_qualified) begin
                    next_s.state = sdirc_pkg::ST_LOCKED;
                end else if (s.acq_cnt == sdirc_pkg::sdirc_tmr_t'(ACQ_LIMIT - 1)) begin
                    // no lock inside the acquisition budget: kick the loop into a fresh search
                    next_s.acq_restart = 1'h1;
                    next_s.acq_cnt = 21'h0;
                end else begin
                    next_s.acq_cnt = s.acq_cnt + 21'h1;
                end
            end
            sdirc_pkg::ST_LOCKED: begin
                if (pin_force) begin
                    next_s.state = sdirc_pkg::ST_FORCED;
                end else if (!s.active) begin
                    next_s.state = sdirc_pkg::ST_IDLE;
                end else if (!rate_ok || (pin_rate != s.det_prev)) begin
                    next_s.state = sdirc_pkg::ST_ACQUIRE;
                    next_s.acq_cnt = 21'h0;
                end
            end
            sdirc_pkg::ST_FORCED: begin
                if (!pin_force) begin
                    next_s.state = sdirc_pkg::ST_IDLE;
                end
            end
            default: begin
                next_s.state = sdirc_pkg::ST_IDLE;
            end
        endcase

        // lock only in the locked state, which needs activity, loop lock and no forced skip
        next_s.locked = (next_s.state == sdirc_pkg::ST_LOCKED);

        // class follows lock after a settle delay; it drops at once when lock goes
        if (!next_s.locked) begin
            next_s.rate_class = 1'h0;
            next_s.class_cnt = 3'h0;
        end else if (s.class_cnt != sdirc_pkg::CLASS_DELAY_LAST) begin
            next_s.class_cnt = s.class_cnt + 3'h1;
        end else begin
            // 8B10B transport at 270 locks like any other 270 stream, fixed or automatic
            next_s.rate_class = (pin_rate == sdirc_pkg::DET_270);
        end

        if (drive_prim) begin
            next_s.sample_valid = 1'h1;
            next_s.prim_true = prim_bit;
            next_s.prim_comp = ~prim_bit;
        end
        if (drive_sec) begin
            next_s.sec_true = sec_bit;
            next_s.sec_comp = ~sec_bit;
        end
        if (prim_quiet) begin
            next_s.prim_true = sdirc_pkg::QUIET_TRUE;
            next_s.prim_comp = sdirc_pkg::QUIET_COMP;
        end
        if (sec_quiet) begin
            next_s.sec_true = sdirc_pkg::QUIET_TRUE;
            next_s.sec_comp = sdirc_pkg::QUIET_COMP;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            s <= sdirc_pkg::STATE_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign primary_serial_out_true_out = s.prim_true;
    assign primary_serial_out_comp_out = s.prim_comp;
    assign second_serial_out_true_out = s.sec_true;
    assign second_serial_out_comp_out = s.sec_comp;
    assign sample_valid_out = s.sample_valid;
    assign lock_indicator_out = s.locked;
    assign rate_class_indicator_out = s.rate_class;
    assign acq_restart_out = s.acq_restart;
    assign test_mode_out = s.test_mode;
endmodule // sdirc_reclocker_ctrl
`default_nettype wire

// ### src/sdirc_skid_buf.sv
/*
 * Two-entry sample buffer with valid/ready on both sides.
 * Assumes the drain side may stall indefinitely; ready upstream drops only when both entries hold data.
 */
`timescale 1ns/1ns
`default_nettype none
module sdirc_skid_buf (
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    sdirc_stream_if.snk fill,
    sdirc_stream_if.src drain
);
    typedef struct packed {
        logic [1:0][1:0] entry;
        logic wptr;
        logic rptr;
        logic [1:0] count;
    } sdirc_buf_t;

    sdirc_buf_t s;
    sdirc_buf_t next_s;
    logic push;
    logic pop;

    assign fill.ready = (s.count != 2'h2);
    assign drain.valid = (s.count != 2'h0);
    assign drain.data_bit = s.entry[s.rptr][1];
    assign drain.half_bit = s.entry[s.rptr][0];
    assign push = fill.valid && fill.ready;
    assign pop = drain.valid && drain.ready;

    always_comb begin
        next_s = s;
        if (push) begin
            next_s.entry[s.wptr] = {fill.data_bit, fill.half_bit};
            next_s.wptr = ~s.wptr;
        end
        if (pop) begin
            next_s.rptr = ~s.rptr;
        end
        case ({push, pop})
            2'b10: next_s.count = s.count + 2'h1;
            2'b01: next_s.count = s.count - 2'h1;
            default: next_s.count = s.count;
        endcase
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule // sdirc_skid_buf
`default_nettype wire

// ### tb/sdirc_front_model.sv
/* model of the front end feeding the block
   assumes the bench supplies random bits and the run and feed controls */
`timescale 1ns/1ns
`default_nettype none
module sdirc_front_model (
    input wire logic clk_sys_in,
    input wire logic run_in,
    input wire logic feed_in,
    input wire logic [15:0] rnd_in,
    input wire logic ready_in,
    output logic serial_out,
    output logic cdr_lock_out,
    output logic bit_out,
    output logic half_out,
    output logic valid_out
);
    logic [2:0] div = 3'h0;
    initial begin
        serial_out = 1'b0;
        cdr_lock_out = 1'b0;
        bit_out = 1'b0;
        half_out = 1'b1;
        valid_out = 1'b0;
    end
    always @(posedge clk_sys_in) begin
        div <= div + 3'h1;
        // without signal the equaliser output stands still
        if (run_in && div == 3'h7) begin
            serial_out <= !serial_out;
        end
        cdr_lock_out <= run_in;
        if (valid_out && !ready_in) begin
            valid_out <= 1'b1;
        end else if (feed_in) begin
            valid_out <= 1'b1;
            bit_out <= rnd_in[0];
            half_out <= !half_out;
        end else begin
            valid_out <= 1'b0;
            bit_out <= !bit_out;
        end
    end
endmodule // sdirc_front_model
`default_nettype wire

// ### tb/sdirc_reclocker_ctrl_properties.sv
/* port-level assertions for the reclocker control block
   assumes it is bound into sdirc_reclocker_ctrl and shares its clock and reset */
`timescale 1ns/1ns
`default_nettype none
module sdirc_reclocker_ctrl_properties #(
    parameter int ACQ_LIMIT = 200,
    parameter int LOS_LIMIT = 50
) (
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    input wire logic serial_in,
    input wire logic cdr_lock_in,
    input wire logic [2:0] cdr_rate_in,
    input wire logic outputs_quiet_n_in,
    input wire logic retime_skip_force_in,
    input wire logic second_output_clock_select_in,
    input wire logic [1:0] rate_select_in,
    input wire logic primary_serial_out_true_out,
    input wire logic primary_serial_out_comp_out,
    input wire logic second_serial_out_true_out,
    input wire logic second_serial_out_comp_out,
    input wire logic sample_valid_out,
    input wire logic lock_indicator_out,
    input wire logic rate_class_indicator_out,
    input wire logic acq_restart_out,
    input wire logic test_mode_out
);
    logic p_quiet;
    logic s_quiet;
    logic lk;
    logic bad_mode;
    assign p_quiet = !primary_serial_out_true_out && primary_serial_out_comp_out;
    assign s_quiet = !second_serial_out_true_out && second_serial_out_comp_out;
    assign lk = lock_indicator_out;
    assign bad_mode = (rate_select_in == 2'h1 && cdr_rate_in != 3'h1) ||
        (rate_select_in == 2'h2 && cdr_rate_in == 3'h1);
    // windows of five cover the two-flop pin sync plus the output register
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_b_in);
    quiet_both_a: assert property ((!outputs_quiet_n_in) [*5] |-> p_quiet && s_quiet)
        else $error("legs not quiet while silenced");
    clock_mute_a: assert property ((second_output_clock_select_in && !lk) [*5] |-> s_quiet)
        else $error("clock output not quiet in bypass");
    legs_opposite_a: assert property (primary_serial_out_true_out != primary_serial_out_comp_out &&
        second_serial_out_true_out != second_serial_out_comp_out) else $error("legs not opposite");
    bypass_pass_a: assert property ((outputs_quiet_n_in && !lk && !second_output_clock_select_in &&
        $stable(serial_in)) [*5] |-> sample_valid_out && primary_serial_out_true_out == serial_in &&
        second_serial_out_true_out == serial_in) else $error("bypass legs do not follow input");
    skip_unlock_a: assert property (retime_skip_force_in [*5] |-> !lk)
        else $error("lock high under forced skip");
    bad_rate_a: assert property ((!cdr_lock_in || cdr_rate_in inside {3'h0, 3'h6, 3'h7}) [*5] |-> !lk)
        else $error("lock on refused rate");
    mode_gate_a: assert property ($rose(lk) |-> !bad_mode)
        else $error("lock on rate outside selected mode");
    restart_pulse_a: assert property (acq_restart_out |-> !lk ##1 !acq_restart_out)
        else $error("restart pulse malformed");
    class_lock_a: assert property (rate_class_indicator_out |-> lk)
        else $error("rate class high while unlocked");
    class_value_a: assert property ((lk && $stable(cdr_rate_in)) [*8] |->
        rate_class_indicator_out == (cdr_rate_in == 3'h1)) else $error("rate class wrong");
    test_flag_a: assert property ($stable(rate_select_in) [*5] |->
        test_mode_out == (rate_select_in == 2'h3)) else $error("test flag wrong");
endmodule // sdirc_reclocker_ctrl_properties
`default_nettype wire

// ### tb/sdirc_reclocker_ctrl_tb.sv
/* self-checking bench for the reclocker control block
   assumes the front model and the bound assertion checker */
`timescale 1ns/1ns
`default_nettype none
module sdirc_reclocker_ctrl_tb;
    localparam int ACQ = 200;
    localparam int LOS = 50;
    logic clk_sys_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic run = 1'b0, feed = 1'b0, quiet_drv = 1'b1, tie = 1'b0, skip = 1'b0, csel = 1'b0;
    logic stall = 1'b0, drv_rdy = 1'b1;
    logic [2:0] rate = 3'h1;
    logic [1:0] rsel = 2'h0;
    logic [1:0] e;
    logic [15:0] seed = 16'h52c3;
    logic ser, cl, rb, rh, rv, rrdy, pt, pc, st, sc, sv, lk, cls, rs, tm, quiet_n;
    int err_count = 0, samples_checked = 0, restarts = 0, r0;
    logic [1:0] exp_q[$];
    // the system clock stands in for the board timing reference
    always #5 clk_sys_in = !clk_sys_in;
    // board option: lock output wired back to the quiet input
    assign quiet_n = tie ? lk : quiet_drv;
    function automatic logic [15:0] xs(input logic [15:0] v);
        logic [15:0] r;
        r = v ^ (v << 7);
        r = r ^ (r >> 9);
        return r ^ (r << 8);
    endfunction
    function automatic logic exp_lock(input logic [1:0] s, input logic [2:0] c);
        return c inside {[3'h1:3'h5]} && !(s == 2'h1 && c != 3'h1) && !(s == 2'h2 && c == 3'h1);
    endfunction
    task automatic chk(input string n, input logic [3:0] x, input logic [3:0] g);
        samples_checked++;
        if (g !== x) begin
            err_count++;
            $display("Error %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic conclude;
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys_in);
    endtask
    task automatic wait_lock(input logic v, input int lim);
        for (int i = 0; i < lim && lk !== v; i++) @(negedge clk_sys_in);
        if (lk !== v) begin
            err_count++;
            $display("Error lock wait expected %h seen %h", v, lk);
            conclude();
        end
    endtask
    always @(negedge clk_sys_in) begin
        seed <= xs(seed);
        drv_rdy <= !stall && (seed[2] || seed[6]);
    end
    // samples taken while locked must leave in order on the legs
    always @(posedge clk_sys_in) begin
        if (rs) restarts <= restarts + 1;
        if (rv && rrdy && lk) exp_q.push_back({rh, rb});
        if (sv && lk && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            chk("primary", {2'h0, e[0], !e[0]}, {2'h0, pt, pc});
            chk("second", {3'h0, csel ? e[1] : e[0]}, {3'h0, st});
        end
    end
    sdirc_front_model u_sdirc_front_model (.clk_sys_in(clk_sys_in), .run_in(run), .feed_in(feed),
        .rnd_in(seed), .ready_in(rrdy), .serial_out(ser), .cdr_lock_out(cl), .bit_out(rb),
        .half_out(rh), .valid_out(rv));
    sdirc_reclocker_ctrl #(.ACQ_LIMIT(ACQ), .LOS_LIMIT(LOS)) u_sdirc_reclocker_ctrl (
        .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .serial_in(ser), .cdr_lock_in(cl),
        .cdr_rate_in(rate), .outputs_quiet_n_in(quiet_n), .retime_skip_force_in(skip),
        .second_output_clock_select_in(csel), .rate_select_in(rsel), .recovered_bit_in(rb),
        .recovered_half_in(rh), .recovered_valid_in(rv), .recovered_ready_out(rrdy),
        .driver_ready_in(drv_rdy), .primary_serial_out_true_out(pt), .primary_serial_out_comp_out(pc),
        .second_serial_out_true_out(st), .second_serial_out_comp_out(sc), .sample_valid_out(sv),
        .lock_indicator_out(lk), .rate_class_indicator_out(cls), .acq_restart_out(rs),
        .test_mode_out(tm));
    initial begin
        cyc(6);
        chk("reset legs", 4'h5, {pt, pc, st, sc});
        chk("reset ready", 4'h1, {lk, sv, rrdy});
        rst_b_in = 1'b1;
        run = 1'b1;
        wait_lock(1'b1, 100);
        cyc(10);
        chk("class sd", 4'h1, {3'h0, cls});
        feed = 1'b1;
        cyc(300);
        feed = 1'b0;
        cyc(10);
        csel = 1'b1;
        cyc(6);
        feed = 1'b1;
        cyc(200);
        stall = 1'b1;
        cyc(10);
        chk("buffer full", 4'h0, {3'h0, rrdy});
        stall = 1'b0;
        feed = 1'b0;
        cyc(20);
        chk("drained", 4'h1, {3'h0, exp_q.size() == 0});
        csel = 1'b0;
        quiet_drv = 1'b0;
        cyc(6);
        chk("quiet legs", 4'h5, {pt, pc, st, sc});
        quiet_drv = 1'b1;
        skip = 1'b1;
        cyc(6);
        chk("skip lock", 4'h0, {3'h0, lk});
        run = 1'b0;
        cyc(8);
        chk("bypass legs", {1'b0, ser, !ser, 1'b1}, {1'b0, pt, pc, sv});
        csel = 1'b1;
        cyc(6);
        chk("clock mute", 4'h1, {2'h0, st, sc});
        quiet_drv = 1'b0;
        cyc(6);
        chk("quiet bypass", 4'h1, {2'h0, pt, pc});
        quiet_drv = 1'b1;
        csel = 1'b0;
        skip = 1'b0;
        run = 1'b1;
        for (int s = 0; s < 4; s++) begin
            for (int c = 0; c < 8; c++) begin
                rsel = 2'(s);
                rate = 3'(c);
                cyc(60);
                chk("lock", {3'h0, exp_lock(rsel, rate)}, {3'h0, lk});
                chk("class", {3'h0, exp_lock(rsel, rate) && rate == 3'h1}, {3'h0, cls});
                chk("test", {3'h0, rsel == 2'h3}, {3'h0, tm});
            end
        end
        rsel = 2'h0;
        rate = 3'h6;
        r0 = restarts;
        cyc(ACQ + 60);
        chk("restart", 4'h1, {3'h0, restarts > r0});
        rate = 3'h1;
        wait_lock(1'b1, 100);
        tie = 1'b1;
        run = 1'b0;
        wait_lock(1'b0, LOS + 30);
        cyc(6);
        chk("tied quiet", 4'h5, {pt, pc, st, sc});
        conclude();
    end
endmodule // sdirc_reclocker_ctrl_tb
bind sdirc_reclocker_ctrl sdirc_reclocker_ctrl_properties #(.ACQ_LIMIT(ACQ_LIMIT), .LOS_LIMIT(LOS_LIMIT))
    u_sdirc_reclocker_ctrl_properties (.*);
`default_nettype wire
